// >>> verilog/edd_consts.svh
// Purpose: offsets, field positions and register indices for the descriptor DMA
// Assumes: included by bare name ahead of the engine and top modules
// Notes:   definitions only
`ifndef EDD_CONSTS_SVH
`define EDD_CONSTS_SVH

// =====================================================================
// descriptor word offsets (bytes)
`define EDD_OFS_CTRL        32'h0000_0000
`define EDD_OFS_BUF         32'h0000_0004
`define EDD_OFS_STAT_HI     32'h0000_0008
`define EDD_OFS_STAT_LO     32'h0000_000C
`define EDD_OFS_LINK        32'h0000_0010
`define EDD_SIZE_NOLINK     32'h0000_0010
`define EDD_SIZE_LINK       32'h0000_0014
// =====================================================================
// word zero field positions
`define EDD_BIT_FIRST       31
`define EDD_BIT_LAST        30
`define EDD_CNT_HI          26
`define EDD_CNT_LO          16
`define EDD_BIT_LINKV       8
`define EDD_BIT_OWN         7
// =====================================================================
// register indices (adr bits 5:2) on the wishbone slave
`define EDD_REG_CTRL        4'h0
`define EDD_REG_TX_START    4'h1
`define EDD_REG_RX_START    4'h2
`define EDD_REG_STATUS      4'h3
`define EDD_REG_TX_CUR      4'h4
`define EDD_REG_RX_CUR      4'h5
`define EDD_REG_TX_PKTS     4'h6
`define EDD_REG_RX_PKTS     4'h7

`endif

// >>> verilog/edd_pkg.sv
// Purpose: shared types of the descriptor DMA
// Assumes: nothing
// Notes:   constants live in edd_consts.svh
package edd_pkg;
  // =====================================================================
  // engine walk states
  typedef enum logic [3:0] {
    EDD_IDLE,
    EDD_RD_CTRL,
    EDD_RD_BUF,
    EDD_RD_LINK,
    EDD_MOVE,
    EDD_WR_STAT_HI,
    EDD_WR_STAT_LO,
    EDD_WR_CTRL,
    EDD_WAIT_STAT
  } edd_state_t;
endpackage

// >>> verilog/edd_dma.sv
// Purpose: descriptor-driven transmit and receive DMA for a 10/100 MAC
// Assumes: classic wishbone masters/slave, one clock, memory answers with ack
// Notes:   one engine module instanced twice, each its own bus master
`timescale 1ns/10ps
`include "edd_consts.svh"

// =====================================================================
// one descriptor engine; IS_RX selects the direction of data movement
module edd_engine
  import edd_pkg::*;
#(
  parameter bit IS_RX = 1'b0
) (
  input  wire logic        ref_clk,     // system clock
  input  wire logic        rst,         // sync reset, high
  input  wire logic        enable,      // engine run
  input  wire logic        start_load,  // pulse: load table start
  input  wire logic [31:0] start_addr,  // table start address
  output logic             m_cyc,       // wishbone master cycle
  output logic             m_stb,       // wishbone master strobe
  output logic             m_we,        // write enable
  output logic [31:0]      m_adr,       // byte address
  output logic [31:0]      m_dat_o,     // write data
  output logic [3:0]       m_sel,       // byte lanes
  input  wire logic [31:0] m_dat_i,     // read data
  input  wire logic        m_ack,       // transfer ack
  output logic             s_valid,     // stream word valid (tx out / rx in ready)
  output logic [31:0]      s_data,      // tx word to mac
  output logic             s_first,     // tx: word starts packet
  output logic             s_last,      // tx: word ends packet
  input  wire logic        s_ready,     // tx: mac accepts / rx: mac has word
  input  wire logic [31:0] s_rdata,     // rx word from mac
  input  wire logic        s_rend,      // rx: word ends packet
  input  wire logic        st_valid,    // status vector ready for this descriptor
  input  wire logic [51:0] st_vec,      // tx status or rx {filter,csum,rsv}
  output logic             st_taken,    // pulse: status written
  output logic [31:0]      cur_desc,    // current descriptor address
  output logic             busy,        // engine walking
  output logic [15:0]      pkt_count    // descriptors completed
);
  edd_state_t  state;
  logic [31:0] ctrl_word;
  logic [31:0] buf_ptr;
  logic [31:0] link_ptr;
  logic [10:0] remain;
  logic [51:0] stat;

  function automatic logic [10:0] bytes_now(input logic [10:0] r);
    bytes_now = (r > 11'h004) ? 11'h004 : r;
  endfunction

  function automatic logic [3:0] lanes(input logic [10:0] r);
    unique case (bytes_now(r))
      11'h001: lanes = 4'h1;
      11'h002: lanes = 4'h3;
      11'h003: lanes = 4'h7;
      default: lanes = 4'hF;
    endcase
  endfunction

  wire logic mem_done = m_cyc && m_ack;
  wire logic own_hw   = m_dat_i[`EDD_BIT_OWN];

  // =====================================================================
  // walk state machine; each engine alone steps its own table
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= EDD_IDLE;
    end else begin
      unique case (state)
        EDD_IDLE:       if (enable) state <= EDD_RD_CTRL;
        EDD_RD_CTRL: begin
          // a software-owned word ends the walk; nothing else is looked at
          if (mem_done) state <= own_hw ? EDD_RD_BUF : EDD_IDLE;
        end
        EDD_RD_BUF: begin
          if (mem_done) state <= ctrl_word[`EDD_BIT_LINKV] ? EDD_RD_LINK : EDD_MOVE;
        end
        EDD_RD_LINK:    if (mem_done) state <= EDD_MOVE;
        EDD_MOVE: begin
          if (remain == 11'h000) state <= EDD_WAIT_STAT;
        end
        EDD_WAIT_STAT: begin
          // status only for the packet's last buffer; earlier ones go straight on
          if (!ctrl_word[`EDD_BIT_LAST] || st_valid) state <= EDD_WR_STAT_HI;
        end
        EDD_WR_STAT_HI: if (mem_done) state <= EDD_WR_STAT_LO;
        EDD_WR_STAT_LO: if (mem_done) state <= EDD_WR_CTRL;
        EDD_WR_CTRL:    if (mem_done) state <= enable ? EDD_RD_CTRL : EDD_IDLE;
      endcase
    end
  end

  // =====================================================================
  // descriptor fields captured from memory
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_word <= 32'h0000_0000;
      buf_ptr   <= 32'h0000_0000;
      link_ptr  <= 32'h0000_0000;
    end else if (mem_done && state == EDD_RD_CTRL) begin
      ctrl_word <= m_dat_i;
    end else if (mem_done && state == EDD_RD_BUF) begin
      buf_ptr <= m_dat_i;
    end else if (mem_done && state == EDD_RD_LINK) begin
      link_ptr <= m_dat_i;
    end else if (mem_done && state == EDD_MOVE) begin
      buf_ptr <= buf_ptr + 32'h0000_0004;
    end
  end

  // =====================================================================
  // byte count of the buffer; zero is never expected from software
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      remain <= 11'h000;
    end else if (mem_done && state == EDD_RD_CTRL) begin
      remain <= m_dat_i[`EDD_CNT_HI:`EDD_CNT_LO];
    end else if (mem_done && state == EDD_MOVE) begin
      // rx end word closes the buffer only once stored, never while in flight
      remain <= (IS_RX && s_rend) ? 11'h000 : remain - bytes_now(remain);
    end
  end

  // =====================================================================
  // status vector latched from the mac; zero for non-final buffers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stat <= 52'h0;
    end else if (state == EDD_RD_CTRL) begin
      stat <= 52'h0;
    end else if (state == EDD_WAIT_STAT && ctrl_word[`EDD_BIT_LAST] && st_valid) begin
      stat <= st_vec;
    end
  end

  // =====================================================================
  // descriptor pointer: link, fall-through, or start register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur_desc <= 32'h0000_0000;
    end else if (start_load && state == EDD_IDLE) begin
      cur_desc <= {start_addr[31:2], 2'b00};
    end else if (mem_done && state == EDD_WR_CTRL) begin
      cur_desc <= ctrl_word[`EDD_BIT_LINKV] ? link_ptr
                : cur_desc + (`EDD_SIZE_NOLINK);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pkt_count <= 16'h0000;
    end else if (mem_done && state == EDD_WR_CTRL) begin
      pkt_count <= pkt_count + 16'h0001;
    end
  end

  // =====================================================================
  // master request; held until ack, then two idle cycles
  logic        req_want;
  logic        req_we;
  logic [31:0] req_adr;
  logic [31:0] req_dat;
  logic [3:0]  req_sel;
  logic        move_ok;

  // rx waits for a mac word; tx writes nothing and never waits on mac space
  assign move_ok = IS_RX ? s_ready : 1'b1;

  always_comb begin
    req_want = 1'b0;
    req_we   = 1'b0;
    req_adr  = cur_desc;
    req_dat  = 32'h0000_0000;
    req_sel  = 4'hF;
    unique case (state)
      EDD_RD_CTRL: req_want = 1'b1;
      EDD_RD_BUF: begin
        req_want = 1'b1;
        req_adr  = cur_desc + (`EDD_OFS_BUF);
      end
      EDD_RD_LINK: begin
        req_want = 1'b1;
        req_adr  = cur_desc + (`EDD_OFS_LINK);
      end
      EDD_MOVE: begin
        req_want = (remain != 11'h000) && move_ok;
        req_we   = IS_RX;
        req_adr  = buf_ptr;
        req_dat  = s_rdata;
        req_sel  = IS_RX ? lanes(remain) : 4'hF;
      end
      EDD_WR_STAT_HI: begin
        req_want = 1'b1;
        req_we   = 1'b1;
        req_adr  = cur_desc + (`EDD_OFS_STAT_HI);
        if (IS_RX) begin
          req_dat = stat[51:20];
        end else begin
          req_dat = {12'h000, stat[51:32]};
          req_sel = 4'h7; // software byte 31-24 untouched
        end
      end
      EDD_WR_STAT_LO: begin
        req_want = 1'b1;
        req_we   = 1'b1;
        req_adr  = cur_desc + (`EDD_OFS_STAT_LO);
        req_dat  = IS_RX ? {stat[19:0], 12'h000} : stat[31:0];
      end
      EDD_WR_CTRL: begin
        // ownership handed back only after both status words landed
        req_want = 1'b1;
        req_we   = 1'b1;
        req_dat  = {24'h000000, 1'b0, 7'h00};
        req_sel  = 4'h1; // only the byte holding the own bit
      end
      default: req_want = 1'b0;
    endcase
  end

  logic gap;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      m_cyc   <= 1'b0;
      m_we    <= 1'b0;
      m_adr   <= 32'h0000_0000;
      m_dat_o <= 32'h0000_0000;
      m_sel   <= 4'h0;
      gap     <= 1'b0;
    end else if (m_cyc) begin
      if (m_ack) begin
        m_cyc <= 1'b0;
        gap   <= 1'b1;
      end
    end else begin
      gap <= 1'b0;
      if (req_want && !gap) begin
        m_cyc   <= 1'b1;
        m_we    <= req_we;
        m_adr   <= req_adr;
        m_dat_o <= req_dat;
        m_sel   <= req_sel;
      end
    end
  end
  assign m_stb = m_cyc;

  // =====================================================================
  // tx stream: each fetched word goes to the mac the cycle after ack
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_valid <= 1'b0;
      s_data  <= 32'h0000_0000;
      s_first <= 1'b0;
      s_last  <= 1'b0;
    end else if (!IS_RX && mem_done && state == EDD_MOVE) begin
      s_valid <= 1'b1;
      s_data  <= m_dat_i;
      s_first <= ctrl_word[`EDD_BIT_FIRST] && (remain == ctrl_word[`EDD_CNT_HI:`EDD_CNT_LO]);
      s_last  <= ctrl_word[`EDD_BIT_LAST] && (remain <= 11'h004);
    end else begin
      s_valid <= IS_RX ? (state == EDD_MOVE && mem_done) : 1'b0;
      s_first <= 1'b0;
      s_last  <= 1'b0;
    end
  end

  assign st_taken = mem_done && state == EDD_WR_STAT_LO;
  assign busy     = state != EDD_IDLE;
endmodule

// =====================================================================
// top: wishbone slave plus two engines
module edd_dma
  import edd_pkg::*;
(
  input  wire logic        ref_clk,     // 40 MHz system clock
  input  wire logic        rst,         // sync reset, high
  input  wire logic [31:0] wb_adr_i,    // slave byte address
  input  wire logic [31:0] wb_dat_i,    // slave write data
  output logic [31:0]      wb_dat_o,    // slave read data
  input  wire logic        wb_we_i,     // slave write
  input  wire logic [3:0]  wb_sel_i,    // slave byte lanes
  input  wire logic        wb_cyc_i,    // slave cycle
  input  wire logic        wb_stb_i,    // slave strobe
  output logic             wb_ack_o,    // slave ack
  output logic             tx_cyc,      // tx master cycle
  output logic             tx_stb,      // tx master strobe
  output logic             tx_we,       // tx master write
  output logic [31:0]      tx_adr,      // tx master address
  output logic [31:0]      tx_dat_o,    // tx master write data
  output logic [3:0]       tx_sel,      // tx master lanes
  input  wire logic [31:0] tx_dat_i,    // tx master read data
  input  wire logic        tx_ack,      // tx master ack
  output logic             rx_cyc,      // rx master cycle
  output logic             rx_stb,      // rx master strobe
  output logic             rx_we,       // rx master write
  output logic [31:0]      rx_adr,      // rx master address
  output logic [31:0]      rx_dat_o,    // rx master write data
  output logic [3:0]       rx_sel,      // rx master lanes
  input  wire logic [31:0] rx_dat_i,    // rx master read data
  input  wire logic        rx_ack,      // rx master ack
  output logic             mtx_valid,   // word to mac valid
  output logic [31:0]      mtx_data,    // word to mac
  output logic             mtx_first,   // packet_first_flag word
  output logic             mtx_last,    // packet_last_flag word
  input  wire logic        mtx_ready,   // mac can take a word
  input  wire logic        mtx_st_valid,// transmit_status_vector ready
  input  wire logic [51:0] mtx_st_vec,  // transmit_status_vector
  output logic             mtx_st_taken,// status consumed
  input  wire logic        mrx_valid,   // mac has rx word
  input  wire logic [31:0] mrx_data,    // rx word
  input  wire logic        mrx_end,     // rx word ends packet
  output logic             mrx_ack,     // rx word stored
  input  wire logic        mrx_st_valid,// rx status ready
  input  wire logic [51:0] mrx_st_vec,  // {receive_filter_status,payload_checksum,rsv}
  output logic             mrx_st_taken // status consumed
);
  logic        tx_en;
  logic        rx_en;
  logic [31:0] tx_start;
  logic [31:0] rx_start;
  logic        tx_load;
  logic        rx_load;
  logic        tx_busy;
  logic        rx_busy;
  logic [31:0] tx_cur;
  logic [31:0] rx_cur;
  logic [15:0] tx_pkts;
  logic [15:0] rx_pkts;

  wire logic       wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic [3:0] wb_idx = wb_adr_i[5:2];

  // =====================================================================
  // slave: one wait state free ack, reads decode adr bits 5:2 only (unused indices read zero), unmapped writes dropped
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      unique case (wb_idx)
        `EDD_REG_CTRL:     wb_dat_o <= {30'h0, rx_en, tx_en};
        `EDD_REG_TX_START: wb_dat_o <= tx_start;
        `EDD_REG_RX_START: wb_dat_o <= rx_start;
        `EDD_REG_STATUS:   wb_dat_o <= {30'h0, rx_busy, tx_busy};
        `EDD_REG_TX_CUR:   wb_dat_o <= tx_cur;
        `EDD_REG_RX_CUR:   wb_dat_o <= rx_cur;
        `EDD_REG_TX_PKTS:  wb_dat_o <= {16'h0000, tx_pkts};
        `EDD_REG_RX_PKTS:  wb_dat_o <= {16'h0000, rx_pkts};
        default:           wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // software register writes; start address loads pointer when idle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_en    <= 1'b0;
      rx_en    <= 1'b0;
      tx_start <= 32'h0000_0000;
      rx_start <= 32'h0000_0000;
    end else if (wb_hit && wb_we_i && wb_adr_i[31:6] == 26'h0) begin
      if (wb_idx == `EDD_REG_CTRL && wb_sel_i[0]) begin
        tx_en <= wb_dat_i[0];
        rx_en <= wb_dat_i[1];
      end
      if (wb_idx == `EDD_REG_TX_START && wb_sel_i == 4'hF) tx_start <= wb_dat_i;
      if (wb_idx == `EDD_REG_RX_START && wb_sel_i == 4'hF) rx_start <= wb_dat_i;
    end
  end

  assign tx_load = wb_hit && wb_we_i && wb_idx == `EDD_REG_TX_START && wb_adr_i[31:6] == 26'h0;
  assign rx_load = wb_hit && wb_we_i && wb_idx == `EDD_REG_RX_START && wb_adr_i[31:6] == 26'h0;

  // =====================================================================
  // two separate engines, two separate masters
  edd_engine #(.IS_RX(1'b0)) u_tx (
    .ref_clk(ref_clk), .rst(rst), .enable(tx_en), .start_load(tx_load),
    .start_addr(wb_dat_i), .m_cyc(tx_cyc), .m_stb(tx_stb), .m_we(tx_we),
    .m_adr(tx_adr), .m_dat_o(tx_dat_o), .m_sel(tx_sel), .m_dat_i(tx_dat_i),
    .m_ack(tx_ack), .s_valid(mtx_valid), .s_data(mtx_data), .s_first(mtx_first),
    .s_last(mtx_last), .s_ready(mtx_ready), .s_rdata(32'h0000_0000), .s_rend(1'b0),
    .st_valid(mtx_st_valid), .st_vec(mtx_st_vec), .st_taken(mtx_st_taken),
    .cur_desc(tx_cur), .busy(tx_busy), .pkt_count(tx_pkts)
  );

  edd_engine #(.IS_RX(1'b1)) u_rx (
    .ref_clk(ref_clk), .rst(rst), .enable(rx_en), .start_load(rx_load),
    .start_addr(wb_dat_i), .m_cyc(rx_cyc), .m_stb(rx_stb), .m_we(rx_we),
    .m_adr(rx_adr), .m_dat_o(rx_dat_o), .m_sel(rx_sel), .m_dat_i(rx_dat_i),
    .m_ack(rx_ack), .s_valid(mrx_ack), .s_data(), .s_first(), .s_last(),
    .s_ready(mrx_valid), .s_rdata(mrx_data), .s_rend(mrx_end),
    .st_valid(mrx_st_valid), .st_vec(mrx_st_vec), .st_taken(mrx_st_taken),
    .cur_desc(rx_cur), .busy(rx_busy), .pkt_count(rx_pkts)
  );
endmodule

// >>> tb/edd_asserts.sv
// Purpose: port-level checks of the descriptor dma
// Assumes: bound to edd_dma, memories ack within a few cycles
// Notes:   one clock domain, reset disables every check
`timescale 1ns/10ps
// =====================================================================
// checker
module edd_asserts (
  input wire logic        ref_clk,      // clock
  input wire logic        rst,          // sync reset
  input wire logic        wb_cyc_i,     // slave cycle
  input wire logic        wb_stb_i,     // slave strobe
  input wire logic        wb_ack_o,     // slave ack
  input wire logic        tx_cyc,       // tx cycle
  input wire logic        tx_we,        // tx write
  input wire logic [31:0] tx_adr,       // tx address
  input wire logic [31:0] tx_dat_o,     // tx write data
  input wire logic [3:0]  tx_sel,       // tx lanes
  input wire logic        tx_ack,       // tx ack
  input wire logic        rx_cyc,       // rx cycle
  input wire logic        rx_we,        // rx write
  input wire logic [31:0] rx_adr,       // rx address
  input wire logic [31:0] rx_dat_o,     // rx write data
  input wire logic        rx_ack,       // rx ack
  input wire logic        mtx_st_taken, // tx status written
  input wire logic        mrx_ack       // rx word stored
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // status write acked, then the byte-0 ownership write
  sequence stat_done_s;
    mtx_st_taken && tx_we && tx_ack;
  endsequence
  sequence own_clear_s;
    tx_cyc && tx_we && tx_sel == 4'h1;
  endsequence
  wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("slave ack missing");
  wb_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("slave ack longer than one cycle");
  tx_hold_a: assert property (tx_cyc && !tx_ack |=> tx_cyc && $stable(tx_adr) && $stable(tx_we))
    else $error("tx request changed before ack");
  tx_gap_a: assert property (tx_cyc && tx_ack |=> !tx_cyc)
    else $error("tx no idle cycle after ack");
  rx_hold_a: assert property (rx_cyc && rx_we && !rx_ack |=> rx_cyc && $stable(rx_adr)
    && $stable(rx_dat_o)) else $error("rx write changed before ack");
  own_order_a: assert property (stat_done_s |-> ##[1:12] own_clear_s)
    else $error("ownership not released after status");
  own_clear_a: assert property (own_clear_s |-> !tx_dat_o[7])
    else $error("ownership write keeps hardware owner");
  rx_store_a: assert property (mrx_ack |-> $past(rx_ack) && $past(rx_we))
    else $error("rx word acked without memory write");
endmodule

// >>> tb/edd_mem.sv
// Purpose: word memory answering one dma master
// Assumes: classic wishbone, byte lanes honoured
// Notes:   1 KB, ack after lag wait cycles
`timescale 1ns/10ps
// =====================================================================
// memory model
module edd_mem (
  input  wire logic        clk,  // clock
  input  wire logic        rst,  // sync reset
  input  wire logic        cyc,  // cycle
  input  wire logic        stb,  // strobe
  input  wire logic        we,   // write
  input  wire logic [31:0] adr,  // byte address
  input  wire logic [31:0] wdat, // write data
  input  wire logic [3:0]  sel,  // lanes
  input  wire logic [1:0]  lag,  // wait cycles
  output logic [31:0]      rdat, // read data
  output logic             ack   // ack
);
  logic [31:0] mem [0:255];
  logic [31:0] q = 32'h0;
  logic [1:0]  cnt = 2'h0;
  // released bus shows the inverse so a stale word never passes
  assign rdat = ack ? q : ~q;
  // one answer per request; plain always since the bench preloads mem
  always @(posedge clk) begin
    ack <= 1'b0;
    if (rst) begin
      cnt <= 2'h0;
    end else if (cyc && stb && !ack) begin
      if (cnt == lag) begin
        ack <= 1'b1;
        cnt <= 2'h0;
        q   <= mem[adr[9:2]]; // word aligned only
        for (int i = 0; i < 4; i++) begin
          if (we && sel[i]) mem[adr[9:2]][8*i+:8] <= wdat[8*i+:8];
        end
      end else begin
        cnt <= cnt + 2'h1;
      end
    end
  end
endmodule

// >>> tb/edd_dma_test.sv
// Purpose: self-checking bench of the descriptor dma
// Assumes: two memory models, the bench plays the mac
// Notes:   one linked tx descriptor, one unlinked rx descriptor
`timescale 1ns/10ps
// =====================================================================
// bench
module edd_dma_test;
  logic        ref_clk = 1'b0, rst = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0, wb_ack_o, tx_cyc, tx_stb, tx_we, tx_ack;
  logic        rx_cyc, rx_stb, rx_we, rx_ack, mtx_valid, mtx_first, mtx_last;
  logic        mtx_st_taken, mrx_ack, mrx_st_taken, mtx_ready = 1'b0;
  logic        mtx_st_valid = 1'b0, mrx_valid = 1'b0, mrx_end = 1'b0, mrx_st_valid = 1'b0;
  logic [3:0]  wb_sel_i = 4'h0, tx_sel, rx_sel;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, rdv, seed, tw0, tw1;
  logic [31:0] tx_adr, tx_dat_o, tx_dat_i, rx_adr, rx_dat_o, rx_dat_i, mtx_data;
  logic [31:0] mrx_data = 32'h0, r[8];
  logic [31:0] ex[4] = '{32'h200, 32'h110, 32'h1, 32'h1};
  logic [51:0] mtx_st_vec = 52'h0, mrx_st_vec = 52'h0;
  logic [33:0] txq[$];
  int          errors = 0, n_compared = 0, cyc_n = 0, rxi = 0, st_n = 0;

  always #12.5 ref_clk = ~ref_clk;

  edd_dma dut (.*);
  edd_mem txm (.clk(ref_clk), .rst(rst), .cyc(tx_cyc), .stb(tx_stb), .we(tx_we),
    .adr(tx_adr), .wdat(tx_dat_o), .sel(tx_sel), .lag(2'h0), .rdat(tx_dat_i), .ack(tx_ack));
  edd_mem rxm (.clk(ref_clk), .rst(rst), .cyc(rx_cyc), .stb(rx_stb), .we(rx_we),
    .adr(rx_adr), .wdat(rx_dat_o), .sel(rx_sel), .lag(2'h3), .rdat(rx_dat_i), .ack(rx_ack));

  // =====================================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [31:0] own_done(input logic [31:0] w);
    return w & 32'hFFFF_FF00;
  endfunction
  task automatic check(input logic [63:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic [31:0] a, d, input logic we);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_we_i  <= we;
    wb_sel_i <= 4'hF;
    // no cycle count assumed; only the bench timeout ends a hung wait
    do begin
      @(posedge ref_clk);
    end while (wb_ack_o !== 1'b1);
    rdv = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic summarize();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // mac side: capture tx words, hand rx words on each store, cut hangs
  always @(posedge ref_clk) begin
    cyc_n <= cyc_n + 1;
    mtx_ready <= ~mtx_ready;
    if (mtx_valid === 1'b1) txq.push_back({mtx_first, mtx_last, mtx_data});
    st_n <= st_n + int'(mtx_st_taken === 1'b1) + int'(mrx_st_taken === 1'b1);
    if (mrx_ack === 1'b1) begin
      rxi <= rxi + 1;
      mrx_valid <= (rxi == 0);
      mrx_end <= (rxi == 0);
      mrx_data <= (rxi == 0) ? r[3] : ~r[3];
    end
    if (cyc_n == 20000) begin
      errors++;
      summarize();
    end
  end

  // =====================================================================
  // main sequence
  initial begin
    seed = 32'h6502DFA1;
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      r[i] = seed;
    end
    // tables built before enable, status zeroed except tx status byte 31-24
    tw0 = 32'hC008_0180 | (r[4] & 32'h3800_FE00); // user bits
    tw1 = r[5] & 32'hFFFF_FF7F; // software owned
    txm.mem[8'h40] = tw0;
    txm.mem[8'h41] = 32'h300;
    txm.mem[8'h42] = r[4] & 32'hFF00_0000;
    txm.mem[8'h43] = 32'h0;
    txm.mem[8'h44] = 32'h200;
    txm.mem[8'h80] = tw1;
    txm.mem[8'hC0] = r[0];
    txm.mem[8'hC1] = r[1];
    rxm.mem[8'h40] = 32'hC00B_0080; // 11 bytes, the mac ends the packet after 8
    rxm.mem[8'h41] = 32'h300;
    rxm.mem[8'h42] = 32'h0;
    rxm.mem[8'h43] = 32'h0;
    rxm.mem[8'h44] = 32'h0;
    rxm.mem[8'hC2] = 32'h0;
    mtx_st_vec = {r[5][19:0], r[6]};
    mrx_st_vec = {r[7][19:0], r[4]};
    mtx_st_valid = 1'b1;
    mrx_st_valid = 1'b1;
    mrx_valid = 1'b1;
    mrx_data = r[2];
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    wb(32'h4, 32'h100, 1'b1);
    wb(32'h8, 32'h100, 1'b1);
    wb(32'h3C, 32'h5A, 1'b1);
    wb(32'h3C, 32'h0, 1'b0);
    check(rdv, 32'h0); // unmapped read
    wb(32'h10, 32'h0, 1'b0);
    check(rdv, 32'h100);
    wb(32'h0, 32'h3, 1'b1);
    // tables left alone while hardware owns them
    for (int n = 0; n < 3000 && (txm.mem[8'h40][7] !== 1'b0 || rxm.mem[8'h40][7] !== 1'b0); n++)
      @(posedge ref_clk);
    repeat (40) @(posedge ref_clk);
    check(txq.size(), 2);
    check(txq[0], {2'b10, r[0]});
    check(txq[1], {2'b01, r[1]});
    check(txm.mem[8'h40], own_done(tw0));
    check({txm.mem[8'h42][31:24], txm.mem[8'h42][19:0]}, {r[4][31:24], r[5][19:0]});
    check(txm.mem[8'h43], r[6]);
    check(txm.mem[8'h80], tw1);
    check(rxm.mem[8'hC0], r[2]);
    check(rxm.mem[8'hC1], r[3]);
    check(rxm.mem[8'h42], {r[7][19:0], r[4][31:20]});
    check(rxm.mem[8'h43], {r[4][19:0], 12'h0});
    check(rxm.mem[8'hC2], 32'h0);
    check(rxm.mem[8'h40], own_done(32'hC00B_0080));
    check(st_n, 2);
    for (int i = 0; i < 4; i++) begin
      wb(32'(32'h10 + 4 * i), 32'h0, 1'b0);
      check(rdv, ex[i]);
    end
    summarize();
  end
endmodule

bind edd_dma edd_asserts chk (.*);
